// ---- pkg/mrc_defs.svh ----
`ifndef MRC_DEFS_SVH
`define MRC_DEFS_SVH
// Notes on behaviour
// - Sender appends 16-bit check to every frame
// - Receiver recomputes check, mismatch flags error
// - Check register starts at all ones
// - Only eight data bits enter check
// - Byte XORed low, register shifts toward LSB
// - Shifted-out one XORs in constant, else none
// - Exactly eight shift steps per byte
// - Register after last byte is check value
// - Single write reply echoes request, new check
// - Multi write reply: addr, 10, start, n, check
// - Reply starts with own slave address
// - Only function codes 03, 06, 10 accepted
// - Register count lies between 1 and 32
// - Failed request answers flagged code plus cause

// ----------------------------------------------------------
// Check computation
// ----------------------------------------------------------
`define MRC_CRC_INIT 16'hFFFF
`define MRC_CRC_POLY 16'hA001

// ----------------------------------------------------------
// Function codes and error replies
// ----------------------------------------------------------
`define MRC_FC_RD 8'h03
`define MRC_FC_WR1 8'h06
`define MRC_FC_WRN 8'h10
`define MRC_EXC_FLAG 8'h80
`define MRC_EXC_FUNC 8'h01
`define MRC_EXC_DATA 8'h03

// ----------------------------------------------------------
// Frame layout
// ----------------------------------------------------------
`define MRC_BUF_LEN 80
`define MRC_REQ_LEN 7'h08
`define MRC_WRN_HDR 8'h09
`define MRC_MIN_LEN 7'h04
`define MRC_CNT_MIN 16'h0001
`define MRC_CNT_MAX 16'h0020
`define MRC_EXC_LEN 7'h03
`define MRC_ECHO_LEN 7'h06
`define MRC_RD_HDR 7'h03
`define MRC_WR1_BASE 7'h04
`define MRC_WRN_BASE 7'h07
`define MRC_FIFO_DEPTH 32
`endif

// ---- pkg/mrc_fifo_if.sv ----
`timescale 1ns/100ps
interface mrc_fifo_if #(parameter int W = 8);
  logic wr_valid;
  logic wr_ready;
  logic [W-1:0] wr_data;
  logic rd_valid;
  logic rd_ready;
  logic [W-1:0] rd_data;

  modport fifo (input wr_valid, input wr_data, input rd_ready,
                output wr_ready, output rd_valid, output rd_data);
  modport user (output wr_valid, output wr_data, output rd_ready,
                input wr_ready, input rd_valid, input rd_data);
endinterface

// ---- pkg/mrc_pkg.sv ----
package mrc_pkg;
  `include "mrc_defs.svh"

  // Frame engine states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_CHECK = 4'h2,
    ST_EXEC = 4'h4,
    ST_RESP = 4'h8
  } mrc_state_t;

  // Fold one data byte into the check register
  function automatic logic [15:0] mrc_crc_upd(input logic [15:0] c,
                                              input logic [7:0] d);
    logic [15:0] x;
    x = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      if (x[0]) begin
        x = (x >> 1) ^ `MRC_CRC_POLY;
      end else begin
        x = x >> 1;
      end
    end
    return x;
  endfunction
endpackage

// ---- rtl/mrc_fifo.sv ----
`timescale 1ns/100ps
module mrc_fifo
  import mrc_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Both sides
  mrc_fifo_if.fifo q
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0] wr_ptr_r;
  logic [AW:0] rd_ptr_r;
  logic full;
  logic empty;

  // Extra pointer bit tells full from empty
  assign full = (wr_ptr_r ^ rd_ptr_r) == {1'b1, {AW{1'b0}}};
  assign empty = wr_ptr_r == rd_ptr_r;
  assign q.wr_ready = !full;
  assign q.rd_valid = !empty;
  assign q.rd_data = mem_r[rd_ptr_r[AW-1:0]];

  // Storage, no reset needed for data
  always_ff @(posedge sys_clk) begin
    if (q.wr_valid && !full) begin
      mem_r[wr_ptr_r[AW-1:0]] <= q.wr_data;
    end
  end

  // Pointers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (q.wr_valid && !full) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (q.rd_ready && !empty) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end
endmodule

// ---- rtl/mrc_frame_engine.sv ----
`timescale 1ns/100ps
`include "mrc_defs.svh"
module mrc_frame_engine
  import mrc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Own station address
  input wire logic [7:0] slave_addr,
  // Received characters, data bits only
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_eof,
  // Reply characters
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] tx_data,
  // Device register port
  output logic reg_rd_en,
  output logic reg_wr_en,
  output logic [15:0] reg_addr,
  output logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  // Status
  output logic crc_err,
  output logic rx_ignored,
  output logic busy
);
  // ----------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------
  mrc_state_t state_r;
  logic [7:0] buf_r [`MRC_BUF_LEN];
  logic [6:0] len_r;
  logic ovf_r;
  logic [15:0] rx_crc_r;
  logic [15:0] crc_p1_r;
  logic [15:0] crc_p2_r;
  logic [7:0] fc_r;
  logic [5:0] n_r;
  logic [15:0] start_r;
  logic [6:0] tx_len_r;
  logic exc_r;
  logic [5:0] cnt_r;
  logic rd_pend_r;
  logic [5:0] rd_idx1_r;
  logic [5:0] rd_idx2_r;
  logic [6:0] tx_idx_r;
  logic [15:0] tx_crc_r;
  logic crc_err_r;
  logic rx_ign_r;
  logic rx_take;
  logic issue;
  logic exec_done;
  logic push;
  logic [7:0] push_data;
  logic [15:0] rcv_crc;
  logic [15:0] req_n;
  logic [7:0] dbl_n;
  logic n_ok;
  logic chk_short;
  logic chk_bad;
  logic chk_mine;
  logic chk_exc;
  logic [7:0] chk_code;
  logic [6:0] wr_base;
  logic [6:0] rd_pos;

  mrc_fifo_if #(.W(8)) txq ();

  // ----------------------------------------------------------
  // Reply buffer
  // ----------------------------------------------------------
  mrc_fifo #(
    .WIDTH(8),
    .DEPTH(`MRC_FIFO_DEPTH)
  ) u_txq (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .q(txq.fifo)
  );

  assign txq.rd_ready = tx_ready;
  assign tx_valid = txq.rd_valid;
  assign tx_data = txq.rd_data;
  assign txq.wr_valid = push;
  assign txq.wr_data = push_data;

  // Bytes arriving outside idle are dropped, frames are not queued
  assign rx_take = (state_r == ST_IDLE) && rx_valid;
  assign busy = state_r != ST_IDLE;
  assign crc_err = crc_err_r;
  assign rx_ignored = rx_ign_r;

  // ----------------------------------------------------------
  // Request checking
  // ----------------------------------------------------------
  // Check field arrives low byte first
  always_comb begin
    rcv_crc = {buf_r[len_r - 7'd1], buf_r[len_r - 7'd2]};
    req_n = {buf_r[4], buf_r[5]};
    n_ok = (req_n >= `MRC_CNT_MIN) && (req_n <= `MRC_CNT_MAX);
    dbl_n = {req_n[6:0], 1'b0};
    chk_short = (len_r < `MRC_MIN_LEN) || ovf_r;
    chk_bad = rcv_crc != crc_p2_r;
    chk_mine = buf_r[0] == slave_addr;
    chk_exc = 1'b1;
    chk_code = `MRC_EXC_DATA;
    // Only three function codes are served
    case (buf_r[1])
      `MRC_FC_RD: chk_exc = !(len_r == `MRC_REQ_LEN && n_ok);
      `MRC_FC_WR1: chk_exc = len_r != `MRC_REQ_LEN;
      `MRC_FC_WRN: chk_exc = !(n_ok && buf_r[6] == dbl_n &&
                               {1'b0, len_r} == dbl_n + `MRC_WRN_HDR);
      default: chk_code = `MRC_EXC_FUNC;
    endcase
  end

  // ----------------------------------------------------------
  // State machine
  // ----------------------------------------------------------
  assign exec_done = (cnt_r == n_r) && !reg_rd_en && !rd_pend_r;

  // Main sequence
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (rx_eof) begin
            state_r <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          // Foreign, damaged or truncated frames get no reply
          if (chk_short || chk_bad || !chk_mine) begin
            state_r <= ST_IDLE;
          end else if (chk_exc) begin
            state_r <= ST_RESP;
          end else begin
            state_r <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          if (exec_done) begin
            state_r <= ST_RESP;
          end
        end
        ST_RESP: begin
          if (push && txq.wr_ready && tx_idx_r == tx_len_r + 7'd1) begin
            state_r <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------
  // Frame buffer, also rewritten in place into the reply
  // ----------------------------------------------------------
  assign rd_pos = `MRC_RD_HDR + {rd_idx2_r, 1'b0};

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      len_r <= '0;
      ovf_r <= 1'b0;
    end else if (rx_take) begin
      if (len_r < 7'(`MRC_BUF_LEN)) begin
        len_r <= len_r + 7'd1;
      end else begin
        ovf_r <= 1'b1;
      end
    end else if (state_r == ST_CHECK) begin
      len_r <= '0;
      ovf_r <= 1'b0;
    end
  end

  // Reply bytes overwrite the request after it was decoded
  always_ff @(posedge sys_clk) begin
    if (rx_take && len_r < 7'(`MRC_BUF_LEN)) begin
      buf_r[len_r] <= rx_data;
    end else if (state_r == ST_CHECK && chk_exc) begin
      buf_r[1] <= buf_r[1] | `MRC_EXC_FLAG;
      buf_r[2] <= chk_code;
    end else if (state_r == ST_CHECK && buf_r[1] == `MRC_FC_RD) begin
      buf_r[2] <= dbl_n;
    end else if (rd_pend_r) begin
      buf_r[rd_pos] <= reg_rdata[15:8];
      buf_r[rd_pos + 7'd1] <= reg_rdata[7:0];
    end
  end

  // ----------------------------------------------------------
  // Receive check register
  // ----------------------------------------------------------
  // Two older values kept so the check field itself is left out
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_crc_r <= `MRC_CRC_INIT;
      crc_p1_r <= `MRC_CRC_INIT;
      crc_p2_r <= `MRC_CRC_INIT;
    end else if (rx_take) begin
      rx_crc_r <= mrc_crc_upd(rx_crc_r, rx_data);
      crc_p1_r <= rx_crc_r;
      crc_p2_r <= crc_p1_r;
    end else if (state_r == ST_CHECK) begin
      rx_crc_r <= `MRC_CRC_INIT;
      crc_p1_r <= `MRC_CRC_INIT;
      crc_p2_r <= `MRC_CRC_INIT;
    end
  end

  // ----------------------------------------------------------
  // Decoded request
  // ----------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fc_r <= '0;
      n_r <= '0;
      start_r <= '0;
      tx_len_r <= '0;
      exc_r <= 1'b0;
    end else if (state_r == ST_CHECK) begin
      fc_r <= buf_r[1];
      start_r <= {buf_r[2], buf_r[3]};
      exc_r <= chk_exc;
      if (chk_exc) begin
        n_r <= '0;
        tx_len_r <= `MRC_EXC_LEN;
      end else if (buf_r[1] == `MRC_FC_WR1) begin
        n_r <= 6'd1;
        tx_len_r <= `MRC_ECHO_LEN;
      end else if (buf_r[1] == `MRC_FC_RD) begin
        n_r <= req_n[5:0];
        tx_len_r <= `MRC_RD_HDR + dbl_n[6:0];
      end else begin
        n_r <= req_n[5:0];
        tx_len_r <= `MRC_ECHO_LEN;
      end
    end
  end

  // ----------------------------------------------------------
  // Register port, one access per cycle
  // ----------------------------------------------------------
  // Writes only run after the frame passed every check
  assign issue = (state_r == ST_EXEC) && (cnt_r < n_r);
  assign wr_base = (fc_r == `MRC_FC_WR1) ? `MRC_WR1_BASE : `MRC_WRN_BASE;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      reg_rd_en <= 1'b0;
      reg_wr_en <= 1'b0;
      reg_addr <= '0;
      reg_wdata <= '0;
      rd_idx1_r <= '0;
      rd_idx2_r <= '0;
      rd_pend_r <= 1'b0;
    end else begin
      reg_rd_en <= issue && fc_r == `MRC_FC_RD;
      reg_wr_en <= issue && fc_r != `MRC_FC_RD;
      reg_addr <= start_r + {10'h000, cnt_r};
      reg_wdata <= {buf_r[wr_base + {cnt_r, 1'b0}],
                    buf_r[wr_base + {cnt_r, 1'b0} + 7'd1]};
      rd_idx1_r <= cnt_r;
      rd_idx2_r <= rd_idx1_r;
      // Read data is taken the cycle after the strobe
      rd_pend_r <= reg_rd_en;
      if (issue) begin
        cnt_r <= cnt_r + 6'd1;
      end else if (state_r != ST_EXEC) begin
        cnt_r <= '0;
      end
    end
  end

  // ----------------------------------------------------------
  // Reply generation
  // ----------------------------------------------------------
  // Body first, then check low and high bytes
  assign push = state_r == ST_RESP;
  always_comb begin
    if (tx_idx_r < tx_len_r) begin
      push_data = buf_r[tx_idx_r];
    end else if (tx_idx_r == tx_len_r) begin
      push_data = tx_crc_r[7:0];
    end else begin
      push_data = tx_crc_r[15:8];
    end
  end

  // Index and transmit check register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_idx_r <= '0;
      tx_crc_r <= `MRC_CRC_INIT;
    end else if (state_r != ST_RESP) begin
      tx_idx_r <= '0;
      tx_crc_r <= `MRC_CRC_INIT;
    end else if (txq.wr_ready) begin
      tx_idx_r <= tx_idx_r + 7'd1;
      if (tx_idx_r < tx_len_r) begin
        tx_crc_r <= mrc_crc_upd(tx_crc_r, push_data);
      end
    end
  end

  // ----------------------------------------------------------
  // Status pulses
  // ----------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      crc_err_r <= 1'b0;
      rx_ign_r <= 1'b0;
    end else begin
      crc_err_r <= state_r == ST_CHECK && !chk_short && chk_bad;
      rx_ign_r <= rx_valid && state_r != ST_IDLE;
    end
  end

  // ----------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------
  a_crc_preset: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_r == ST_CHECK |=> rx_crc_r == `MRC_CRC_INIT)
    else $error("check register not preset after frame");

  a_crc_residue: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_r == ST_CHECK && !chk_short && !chk_bad |-> rx_crc_r == 16'h0000)
    else $error("good frame leaves nonzero residue");

  a_crc_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_r == ST_CHECK && !chk_short && chk_bad
    |=> crc_err && state_r == ST_IDLE ##1 !crc_err)
    else $error("mismatch not flagged for one cycle");

  a_resp_addr: assert property (@(posedge sys_clk) disable iff (!rst_n)
    push && tx_idx_r == 7'd0 |-> push_data == slave_addr)
    else $error("reply does not start with own address");

  a_write_code: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_wr_en |-> !exc_r && (fc_r == `MRC_FC_WR1 || fc_r == `MRC_FC_WRN))
    else $error("register written by unsupported request");

  a_count_range: assert property (@(posedge sys_clk)
    disable iff (!rst_n) reg_rd_en |-> n_r >= 6'd1 && n_r <= 6'd32)
    else $error("read count outside range");

  a_crc_order: assert property (@(posedge sys_clk) disable iff (!rst_n)
    push && txq.wr_ready && tx_idx_r == tx_len_r
    |-> push_data == tx_crc_r[7:0]
    ##1 push && push_data == $past(tx_crc_r[15:8]))
    else $error("check bytes sent out of order");

  a_exc_mark: assert property (@(posedge sys_clk) disable iff (!rst_n)
    push && exc_r && tx_idx_r == 7'd1 |-> push_data[7] && tx_len_r == 7'd3)
    else $error("error reply not marked");

  a_read_len: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_r == ST_EXEC && fc_r == `MRC_FC_RD
    |-> tx_len_r == 7'd3 + {n_r, 1'b0} && buf_r[2] == {1'b0, n_r, 1'b0})
    else $error("read reply length wrong");

  a_exec_bound: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(state_r == ST_EXEC) |-> ##[1:40] state_r == ST_RESP)
    else $error("register phase did not finish");
endmodule

// ---- testbench/mrc_frame_engine_tb.sv ----
`timescale 1ns/100ps
module mrc_frame_engine_tb;
  logic sys_clk, rst_n, rx_valid, rx_eof, tx_valid, tx_ready;
  logic reg_rd_en, reg_wr_en, crc_err, rx_ignored, busy;
  logic [7:0] rx_data, tx_data;
  logic [15:0] reg_addr, reg_wdata;
  logic [15:0] reg_rdata = 16'h0000;
  logic [15:0] mem [64];
  int n_mismatch, samples_checked, n_crc;

  // ----------------------------------------------------------
  // Clock, slave, host and register file
  // ----------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  mrc_frame_engine mrc_frame_engine_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .slave_addr(8'h01),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_eof(rx_eof),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .reg_rd_en(reg_rd_en), .reg_wr_en(reg_wr_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .crc_err(crc_err),
    .rx_ignored(rx_ignored), .busy(busy));

  mrc_host_model host_inst (
    .sys_clk(sys_clk), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_eof(rx_eof), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready));

  // Register file: read data follows the strobe by one cycle
  always @(posedge sys_clk) begin
    if (reg_wr_en === 1'b1) begin
      mem[reg_addr[5:0]] <= reg_wdata;
    end
    if (reg_rd_en === 1'b1) begin
      reg_rdata <= mem[reg_addr[5:0]];
    end
  end

  // Error pulses are counted where they are settled
  always @(negedge sys_clk) begin
    if (crc_err === 1'b1) begin
      n_crc++;
    end
  end

  // ----------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic void seal(ref logic [7:0] q[$]);
    logic [15:0] c;
    c = host_inst.crc16(q);
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
  endfunction

  // Drains a reply, compares every byte, then expects silence
  task automatic finish(input logic [7:0] e[$], input bit stall);
    host_inst.collect(e.size(), stall);
    check(32'(host_inst.got.size()), 32'(e.size()));
    foreach (e[i]) begin
      check(32'(host_inst.got[i]), 32'(e[i]));
    end
    repeat (40) @(negedge sys_clk);
    check(32'(tx_valid), 32'h0000_0000);
  endtask

  task automatic xact(input logic [7:0] r[$], input logic [7:0] e[$]);
    host_inst.send(r, 1'b0);
    finish(e, 1'b0);
  endtask

  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  task automatic t_read_pair();
    logic [7:0] r[$];
    r = '{8'h01, 8'h03, 8'h00, 8'h02, 8'h00, 8'h02};
    check(32'(host_inst.crc16(r)), 32'h0000_cb65);
    xact(r, '{8'h01, 8'h03, 8'h04, 8'h01, 8'hf4, 8'h13, 8'h88,
              8'hb7, 8'h6b});
  endtask

  task automatic t_writes();
    xact('{8'h01, 8'h06, 8'h00, 8'h00, 8'h09, 8'h60},
         '{8'h01, 8'h06, 8'h00, 8'h00, 8'h09, 8'h60, 8'h8f, 8'hb2});
    check(32'(mem[0]), 32'h0000_0960);
    mem[0] = 16'h0000;
    host_inst.send('{8'h01, 8'h10, 8'h00, 8'h00, 8'h00, 8'h02, 8'h04,
                     8'h09, 8'h60, 8'h05, 8'hdc}, 1'b0);
    finish('{8'h01, 8'h10, 8'h00, 8'h00, 8'h00, 8'h02, 8'h41, 8'hc8},
           1'b1);
    check(32'(mem[0]), 32'h0000_0960);
    check(32'(mem[1]), 32'h0000_05dc);
  endtask

  // Largest read is longer than the reply buffer while the host stalls
  task automatic t_full_read();
    logic [7:0] e[$];
    int t;
    e = '{8'h01, 8'h03, 8'h40};
    for (int i = 0; i < 32; i++) begin
      e.push_back(8'ha0);
      e.push_back(8'(8'h20 + i));
    end
    seal(e);
    host_inst.send('{8'h01, 8'h03, 8'h00, 8'h20, 8'h00, 8'h20}, 1'b0);
    t = 0;
    while (busy !== 1'b1 && t < 100) begin
      @(negedge sys_clk);
      t++;
    end
    host_inst.poke();
    @(negedge sys_clk);
    check(32'(rx_ignored), 32'h0000_0001);
    finish(e, 1'b1);
  endtask

  // Unsupported code, counts outside 1..32, inconsistent byte count
  task automatic t_refusals();
    logic [7:0] e1[$], e3[$], w3[$];
    e1 = '{8'h01, 8'h85, 8'h01};
    e3 = '{8'h01, 8'h83, 8'h03};
    w3 = '{8'h01, 8'h90, 8'h03};
    seal(e1);
    seal(e3);
    seal(w3);
    xact('{8'h01, 8'h05, 8'h00, 8'h00, 8'h00, 8'h01}, e1);
    xact('{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00}, e3);
    xact('{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h21}, e3);
    xact('{8'h01, 8'h10, 8'h00, 8'h00, 8'h00, 8'h01, 8'h03,
           8'h12, 8'h34}, w3);
  endtask

  // Corrupted check, a frame for another station, then a runt frame
  task automatic t_silent();
    n_crc = 0;
    host_inst.send('{8'h01, 8'h03, 8'h00, 8'h02, 8'h00, 8'h01}, 1'b1);
    repeat (40) @(negedge sys_clk);
    check(32'(n_crc), 32'h0000_0001);
    check(32'(tx_valid), 32'h0000_0000);
    host_inst.send('{8'h02, 8'h03, 8'h00, 8'h02, 8'h00, 8'h01}, 1'b0);
    repeat (40) @(negedge sys_clk);
    check(32'(n_crc), 32'h0000_0001);
    check(32'(tx_valid), 32'h0000_0000);
    // Three bytes are too short to judge: no error pulse, no reply
    host_inst.send('{8'h01}, 1'b1);
    repeat (40) @(negedge sys_clk);
    check(32'(n_crc), 32'h0000_0001);
    check(32'(tx_valid), 32'h0000_0000);
  endtask

  // ----------------------------------------------------------
  // Verdict, main sequence and watchdog
  // ----------------------------------------------------------
  task automatic conclude();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    n_mismatch = 0;
    samples_checked = 0;
    n_crc = 0;
    foreach (mem[i]) begin
      mem[i] = 16'ha000 + 16'(i);
    end
    mem[2] = 16'h01f4;
    mem[3] = 16'h1388;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(negedge sys_clk);
    check(32'({busy, tx_valid}), 32'h0000_0000);
    t_read_pair();
    t_writes();
    t_full_read();
    t_refusals();
    t_silent();
    conclude();
  end

  // Whole run needs under a thousand cycles; this leaves ample room
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    conclude();
  end
endmodule

// ---- testbench/mrc_host_model.sv ----
`timescale 1ns/100ps
// ----------------------------------------------------------
// Host master: sends requests, drains the reply stream
// ----------------------------------------------------------
module mrc_host_model (
  // Clock
  input wire logic sys_clk,
  // Request characters towards the slave
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_eof,
  // Reply characters from the slave
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready
);
  logic [7:0] got[$];

  // Idle levels at time zero
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_eof = 1'b0;
    tx_ready = 1'b0;
  end

  // Bit-serial check, kept apart from the slave's own arithmetic
  function automatic logic [15:0] crc16(input logic [7:0] f[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (f[i]) begin
      c = c ^ {8'h00, f[i]};
      repeat (8) begin
        c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
      end
    end
    return c;
  endfunction

  // One request, check appended; bad flips one check bit
  task automatic send(input logic [7:0] f[$], input bit bad);
    logic [15:0] c;
    c = crc16(f) ^ {15'h0000, bad};
    f.push_back(c[7:0]);
    f.push_back(c[15:8]);
    foreach (f[i]) begin
      @(posedge sys_clk);
      rx_valid <= 1'b1;
      rx_data <= f[i];
    end
    @(posedge sys_clk);
    rx_valid <= 1'b0;
    rx_data <= ~f[f.size()-1]; // Released line never shows the old byte
    rx_eof <= 1'b1;
    @(posedge sys_clk);
    rx_eof <= 1'b0;
  endtask

  // A stray character, meant to arrive while the slave is busy
  task automatic poke();
    @(posedge sys_clk);
    rx_valid <= 1'b1;
    @(posedge sys_clk);
    rx_valid <= 1'b0;
  endtask

  // Takes n reply bytes; stall accepts only every other cycle
  task automatic collect(input int n, input bit stall);
    int t;
    t = 0;
    got.delete();
    while (got.size() < n && t < 4000) begin
      @(negedge sys_clk);
      t++;
      if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
        got.push_back(tx_data);
      end
      @(posedge sys_clk);
      tx_ready <= (got.size() < n) && (stall ? ~tx_ready : 1'b1);
    end
  endtask
endmodule
